//--- verilog/pspr_pkg.sv
// Purpose: Shared constants and types of the PLL serial port ends
// Assumes: 250 MHz system clock on both ends
// Notes:   Frame edges count rising serial clock edges from one
package pspr_pkg;
   // Timing
   localparam int PSPR_CLK_NS       = 4;
   localparam int PSPR_SCLK_HALF_NS = 48;
   localparam int PSPR_HALF_CYC     = PSPR_SCLK_HALF_NS / PSPR_CLK_NS;

   // Field widths
   localparam int PSPR_DATA_W  = 24;
   localparam int PSPR_LADDR_W = 6;
   localparam int PSPR_MADDR_W = 5;
   localparam int PSPR_CHIP_W  = 3;

   // Own chip select value on a shared multi-device bus
   localparam logic [2:0] PSPR_CHIP_ADDR = 3'h0;

   // Rising-edge numbers within a frame
   localparam logic [5:0] PSPR_E_RW         = 6'h01;
   localparam logic [5:0] PSPR_E_ADDR_LAST  = 6'h07;
   localparam logic [5:0] PSPR_E_DATA_FIRST = 6'h08;
   localparam logic [5:0] PSPR_E_DATA_LAST  = 6'h1F;
   localparam logic [5:0] PSPR_E_END        = 6'h20;
   localparam logic [5:0] PSPR_E_MDATA_LAST = 6'h18;
   localparam logic [5:0] PSPR_E_SAT        = 6'h3F;

   // Multi-device frame layout, bit 31 first on the wire
   localparam int PSPR_CHIP_SELECT_ADDRESS_FIELD = 0;
   localparam int PSPR_REGISTER_ADDRESS_FIELD    = 3;
   localparam int PSPR_FRAME_DATA_FIELD          = 8;

   // Register 0 fields in multi-device mode
   localparam int PSPR_R0_RADDR_LSB = 0;
   localparam int PSPR_R0_SRST_BIT  = 5;

   // Link bit positions in the device's sampled vector
   localparam int PSPR_IDX_SDI  = 0;
   localparam int PSPR_IDX_SCLK = 1;
   localparam int PSPR_IDX_ENA  = 2;

   // Host register word offsets
   localparam logic [2:0] PSPR_OFS_CTRL  = 3'h0;
   localparam logic [2:0] PSPR_OFS_ADDR  = 3'h1;
   localparam logic [2:0] PSPR_OFS_WDATA = 3'h2;
   localparam logic [2:0] PSPR_OFS_CHIP  = 3'h3;
   localparam logic [2:0] PSPR_OFS_RDATA = 3'h4;

   // Control and status bits
   localparam int PSPR_CTRL_KIND_LSB = 0;
   localparam int PSPR_CTRL_START    = 2;
   localparam int PSPR_STAT_BUSY     = 0;
   localparam int PSPR_STAT_DONE     = 1;

   typedef enum logic [1:0] {
      PSPR_K_LREAD  = 2'h0,
      PSPR_K_MWRITE = 2'h1,
      PSPR_K_MREAD  = 2'h2
   } pspr_kind_t;

   typedef enum logic [1:0] {
      PSPR_M_NONE   = 2'h0,
      PSPR_M_LEGACY = 2'h1,
      PSPR_M_MULTI  = 2'h3
   } pspr_mode_t;

   typedef enum logic [2:0] {
      PSPR_H_IDLE = 3'h0,
      PSPR_H_LEAD = 3'h1,
      PSPR_H_HIGH = 3'h3,
      PSPR_H_LOW  = 3'h2,
      PSPR_H_TAIL = 3'h6,
      PSPR_H_GAP  = 3'h4
   } pspr_hstate_t;
endpackage : pspr_pkg

//--- verilog/pspr_if.sv
// Purpose: Four-wire serial link between host and PLL serial port
// Assumes: All wires one-way, the shared pin driven only by the device
// Notes:   No clocking block; both ends sample on their own clock
`timescale 1ns/100ps
interface pspr_if;
   logic serial_port_enable;
   logic sclk;
   logic sdi;
   logic lock_or_serial_out_pin;

   modport device (
      input  serial_port_enable,
      input  sclk,
      input  sdi,
      output lock_or_serial_out_pin
   );

   modport host (
      output serial_port_enable,
      output sclk,
      output sdi,
      input  lock_or_serial_out_pin
   );
endinterface : pspr_if

//--- verilog/pspr_device.sv
// Purpose: Device end of the PLL serial control port
// Assumes: rd_data_i follows rd_addr_o within one clock
// Notes:   Link pins are oversampled; edges seen three to four clocks late
//
// How it works
// - Legacy read starts when first bit high
// - Six address bits on rising edges 2-7
// - Pin carries 24 data bits, edges 8-31
// - Host samples each bit on next fall
// - Edge 32 gives pin back to lock
// - Host drops enable to end legacy read
// - Lock shown whenever pin carries no data
// - Multi frame opens with 24 data bits
// - Then five register address bits, edges 25-29
// - Then chip address bits 30-32, ours zero
// - Enable rise after edge 32 commits data
// - Pin shows register chosen by read address
// - Host writes target into register zero
// - Host pulses enable high after first read frame
// - Host resends register zero in second frame
// - Second frame pin carries requested register
// - Enable rise ends frame, pin back to lock
// - Up to eight chips share one bus
// - First enable or clock edge fixes mode
// - Register zero holds read address, soft reset
`timescale 1ns/100ps
module pspr_device
   import pspr_pkg::*;
#(
   parameter logic [2:0] CHIP_ADDR = PSPR_CHIP_ADDR
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   pspr_if.device           link,
   input  wire logic        lock_indicator_i,
   input  wire logic [23:0] rd_data_i,
   output logic      [5:0]  rd_addr_o,
   output logic             wr_stb_o,
   output logic      [4:0]  wr_addr_o,
   output logic      [23:0] wr_data_o,
   output logic      [1:0]  mode_o,
   output logic             soft_rst_o
);

   logic       [2:0]  raw;
   logic       [2:0]  s1;
   logic       [2:0]  s2;
   logic       [2:0]  s3;
   logic       [2:0]  lvl;
   logic       [2:0]  next_lvl;
   logic       [2:0]  rise;
   logic       [2:0]  fall;
   pspr_mode_t        mode;
   pspr_mode_t        next_mode;
   logic       [5:0]  cnt;
   logic       [5:0]  next_cnt;
   logic       [31:0] rx;
   logic       [23:0] tx;
   logic              is_rd;
   logic              drive;
   logic              dout;
   logic              sdi;
   logic              ev_l;
   logic              ev_m;
   logic              commit;
   logic       [4:0]  raddr;
   logic              pin_q;

   assign raw = {link.serial_port_enable, link.sclk, link.sdi};

   // Three stages; only the last two are ever compared
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1  <= 3'h0;
         s2  <= 3'h0;
         s3  <= 3'h0;
         lvl <= 3'h0;
      end else if (ce_i) begin
         s1  <= raw;
         s2  <= s1;
         s3  <= s2;
         lvl <= next_lvl;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         assign next_lvl[gi] = (s2[gi] == s3[gi]) ? s3[gi] : lvl[gi];
      end
   endgenerate

   assign rise = next_lvl & ~lvl;
   assign fall = ~next_lvl & lvl;
   assign sdi  = next_lvl[PSPR_IDX_SDI];

   // Mode fixed by whichever edge comes first after power-on
   always_comb begin
      next_mode = mode;
      if (mode == PSPR_M_NONE) begin
         if (rise[PSPR_IDX_ENA]) begin
            next_mode = PSPR_M_LEGACY;
         end else if (rise[PSPR_IDX_SCLK]) begin
            next_mode = PSPR_M_MULTI;
         end
      end
   end

   // Soft reset leaves the mode alone: only rst_n_i clears it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode   <= PSPR_M_NONE;
         mode_o <= 2'h0;
      end else if (ce_i) begin
         mode   <= next_mode;
         mode_o <= next_mode;
      end
   end

   assign next_cnt = (cnt == PSPR_E_SAT) ? cnt : cnt + 6'h01;
   assign ev_l = rise[PSPR_IDX_SCLK] & lvl[PSPR_IDX_ENA]
               & (next_mode == PSPR_M_LEGACY);
   assign ev_m = rise[PSPR_IDX_SCLK] & ~lvl[PSPR_IDX_ENA]
               & (next_mode == PSPR_M_MULTI);

   // Frame shifting and data launch
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt   <= 6'h00;
         rx    <= 32'h0000_0000;
         tx    <= 24'h00_0000;
         is_rd <= 1'b0;
         drive <= 1'b0;
         dout  <= 1'b0;
      end else if (ce_i) begin
         if (rise[PSPR_IDX_ENA] | fall[PSPR_IDX_ENA]) begin
            cnt   <= 6'h00;
            drive <= 1'b0;
         end else if (ev_l) begin
            cnt <= next_cnt;
            rx  <= {rx[30:0], sdi};
            if (next_cnt == PSPR_E_RW) begin
               is_rd <= sdi;
            end
            if (is_rd && next_cnt == PSPR_E_DATA_FIRST) begin
               drive <= 1'b1;
               dout  <= rd_data_i[23];
               tx    <= {rd_data_i[22:0], 1'b0};
            end else if (next_cnt > PSPR_E_DATA_FIRST
                         && next_cnt <= PSPR_E_DATA_LAST) begin
               dout <= tx[23];
               tx   <= {tx[22:0], 1'b0};
            end
            if (next_cnt == PSPR_E_END) begin
               drive <= 1'b0;
            end
         end else if (ev_m) begin
            cnt <= next_cnt;
            rx  <= {rx[30:0], sdi};
            if (next_cnt == PSPR_E_RW) begin
               // Every frame reads back; that is how multi-device reads work
               drive <= 1'b1;
               dout  <= rd_data_i[23];
               tx    <= {rd_data_i[22:0], 1'b0};
            end else if (next_cnt <= PSPR_E_MDATA_LAST) begin
               dout <= tx[23];
               tx   <= {tx[22:0], 1'b0};
            end
         end
      end
   end

   // Exactly 32 edges and our chip address, else the frame is foreign
   assign commit = rise[PSPR_IDX_ENA] & (mode == PSPR_M_MULTI)
                 & (cnt == PSPR_E_END)
                 & (rx[PSPR_CHIP_SELECT_ADDRESS_FIELD +: PSPR_CHIP_W]
                    == CHIP_ADDR);

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         raddr      <= 5'h00;
         wr_stb_o   <= 1'b0;
         wr_addr_o  <= 5'h00;
         wr_data_o  <= 24'h00_0000;
         soft_rst_o <= 1'b0;
      end else if (ce_i) begin
         wr_stb_o   <= 1'b0;
         soft_rst_o <= 1'b0;
         if (commit) begin
            if (rx[PSPR_REGISTER_ADDRESS_FIELD +: PSPR_MADDR_W] == 5'h00) begin
               // Upper bits of register zero are ignored
               raddr <= rx[PSPR_FRAME_DATA_FIELD + PSPR_R0_RADDR_LSB
                           +: PSPR_MADDR_W];
               if (rx[PSPR_FRAME_DATA_FIELD + PSPR_R0_SRST_BIT]) begin
                  raddr      <= 5'h00;
                  soft_rst_o <= 1'b1;
               end
            end else begin
               wr_stb_o  <= 1'b1;
               wr_addr_o <= rx[PSPR_REGISTER_ADDRESS_FIELD +: PSPR_MADDR_W];
               wr_data_o <= rx[PSPR_FRAME_DATA_FIELD +: PSPR_DATA_W];
            end
         end
      end
   end

   // Address for the register source outside
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_addr_o <= 6'h00;
      end else if (ce_i) begin
         if (ev_l && next_cnt == PSPR_E_ADDR_LAST) begin
            rd_addr_o <= {rx[4:0], sdi};
         end else if (mode == PSPR_M_MULTI) begin
            rd_addr_o <= {1'b0, raddr};
         end
      end
   end

   // Shared pin shows lock detect whenever no data is being driven
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_q <= 1'b0;
      end else if (ce_i) begin
         pin_q <= drive ? dout : lock_indicator_i;
      end
   end

   assign link.lock_or_serial_out_pin = pin_q;

endmodule : pspr_device

//--- verilog/pspr_host.sv
// Purpose: Host end that drives the PLL serial port from registers
// Assumes: Avalon-MM slave with word addresses and waitrequest
// Notes:   Serial clock made by a divider; half period is HALF clocks
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module pspr_host
   import pspr_pkg::*;
#(
   parameter int HALF = PSPR_HALF_CYC
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   pspr_if.host             link,
   input  wire logic [2:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o
);

   localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

   function automatic logic [31:0] frame_of(input pspr_kind_t k,
                                            input logic [5:0] a,
                                            input logic [23:0] d,
                                            input logic [2:0] c);
      logic [31:0] f;
      f = 32'h0000_0000;
      unique case (k)
         PSPR_K_MWRITE: f = {d, a[4:0], c};
         // Same register-zero frame sent twice for a read
         PSPR_K_MREAD:  f = {19'h0_0000, a[4:0], 5'h00, c};
         default:       f = {1'b1, a, 25'h000_0000};
      endcase
      return f;
   endfunction : frame_of

   pspr_kind_t         kind;
   pspr_kind_t         kind_w;
   pspr_hstate_t       st;
   logic        [5:0]  addr;
   logic        [23:0] wdata;
   logic        [2:0]  chip;
   logic        [23:0] rdata;
   logic        [23:0] rx;
   logic        [31:0] sh;
   logic        [31:0] frm;
   logic        [31:0] frm_w;
   logic        [7:0]  div;
   logic        [5:0]  cnt;
   logic               busy;
   logic               done;
   logic               second;
   logic               legacy;
   logic               acc;
   logic               start;
   logic               grab;
   logic               p1;
   logic               p2;
   logic               p3;
   logic               plvl;
   logic               ena_q;
   logic               sclk_q;
   logic               sdi_q;

   assign acc    = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
   assign kind_w = pspr_kind_t'(avs_writedata_i[PSPR_CTRL_KIND_LSB +: 2]);
   assign start  = acc & avs_write_i & (avs_address_i == PSPR_OFS_CTRL)
                 & avs_writedata_i[PSPR_CTRL_START] & ~busy;
   assign frm    = frame_of(kind, addr, wdata, chip);
   assign frm_w  = frame_of(kind_w, addr, wdata, chip);
   assign grab   = legacy ? (cnt >= PSPR_E_DATA_FIRST
                             && cnt <= PSPR_E_DATA_LAST)
                          : (cnt >= PSPR_E_RW
                             && cnt <= PSPR_E_MDATA_LAST);

   // One wait cycle per request, then the answer
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
         kind              <= PSPR_K_LREAD;
         addr              <= 6'h00;
         wdata             <= 24'h00_0000;
         chip              <= 3'h0;
      end else if (ce_i) begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i)
                                & avs_waitrequest_o);
         // Loaded a cycle early so it stands at the accepting edge
         if (avs_read_i && avs_waitrequest_o) begin
            unique case (avs_address_i)
               PSPR_OFS_CTRL:  avs_readdata_o <= {30'h0, done, busy};
               PSPR_OFS_ADDR:  avs_readdata_o <= {26'h0, addr};
               PSPR_OFS_WDATA: avs_readdata_o <= {8'h00, wdata};
               PSPR_OFS_CHIP:  avs_readdata_o <= {29'h0, chip};
               PSPR_OFS_RDATA: avs_readdata_o <= {8'h00, rdata};
               default:        avs_readdata_o <= 32'h0000_0000;
            endcase
         end
         if (acc && avs_write_i) begin
            unique case (avs_address_i)
               PSPR_OFS_CTRL:  if (!busy) kind <= kind_w;
               PSPR_OFS_ADDR:  addr <= avs_writedata_i[5:0];
               PSPR_OFS_WDATA: wdata <= avs_writedata_i[23:0];
               PSPR_OFS_CHIP:  chip <= avs_writedata_i[2:0];
               default:        ;
            endcase
         end
      end
   end

   // Shared pin comes from the device's clock domain
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p1   <= 1'b0;
         p2   <= 1'b0;
         p3   <= 1'b0;
         plvl <= 1'b0;
      end else if (ce_i) begin
         p1 <= link.lock_or_serial_out_pin;
         p2 <= p1;
         p3 <= p2;
         if (p2 == p3) begin
            plvl <= p3;
         end
      end
   end

   // Frame engine: one state step per half serial clock
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st     <= PSPR_H_IDLE;
         busy   <= 1'b0;
         done   <= 1'b0;
         second <= 1'b0;
         legacy <= 1'b0;
         sh     <= 32'h0000_0000;
         rx     <= 24'h00_0000;
         rdata  <= 24'h00_0000;
         div    <= 8'h00;
         cnt    <= 6'h00;
         ena_q  <= 1'b0;
         sclk_q <= 1'b0;
         sdi_q  <= 1'b0;
      end else if (ce_i) begin
         if (st != PSPR_H_IDLE && div != 8'h00) begin
            div <= div - 8'h01;
         end else begin
            div <= HALF_M1;
            unique case (st)
               PSPR_H_IDLE: if (start) begin
                  busy   <= 1'b1;
                  done   <= 1'b0;
                  second <= (kind_w == PSPR_K_MREAD);
                  legacy <= (kind_w == PSPR_K_LREAD);
                  sh     <= frm_w;
                  sdi_q  <= frm_w[31];
                  ena_q  <= (kind_w == PSPR_K_LREAD);
                  cnt    <= 6'h00;
                  st     <= PSPR_H_LEAD;
               end
               PSPR_H_LEAD, PSPR_H_LOW: begin
                  sclk_q <= 1'b1;
                  cnt    <= cnt + 6'h01;
                  st     <= PSPR_H_HIGH;
               end
               PSPR_H_HIGH: begin
                  sclk_q <= 1'b0;
                  sh     <= {sh[30:0], 1'b0};
                  sdi_q  <= sh[30];
                  if (grab) begin
                     rx <= {rx[22:0], plvl};
                  end
                  st <= (cnt == PSPR_E_END) ? PSPR_H_TAIL : PSPR_H_LOW;
               end
               PSPR_H_TAIL: if (!legacy && !ena_q) begin
                  ena_q <= 1'b1;
               end else begin
                  ena_q <= 1'b0;
                  st    <= PSPR_H_GAP;
               end
               PSPR_H_GAP: if (second) begin
                  second <= 1'b0;
                  sh     <= frm;
                  sdi_q  <= frm[31];
                  cnt    <= 6'h00;
                  st     <= PSPR_H_LEAD;
               end else begin
                  busy  <= 1'b0;
                  done  <= 1'b1;
                  rdata <= rx;
                  st    <= PSPR_H_IDLE;
               end
               default: st <= PSPR_H_IDLE;
            endcase
         end
      end
   end

   assign link.serial_port_enable = ena_q;
   assign link.sclk               = sclk_q;
   assign link.sdi                = sdi_q;

endmodule : pspr_host

//--- dv/pspr_monitor.sv
// Purpose: Wire checks on the link between host and device ends
// Assumes: Half periods of at least eight clocks
// Notes:   Lock level held still while frames run
`timescale 1ns/100ps
module pspr_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic serial_port_enable,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic lock_or_serial_out_pin,
   input wire logic lock_indicator_i
);
   logic [5:0] rises;
   logic       seen;
   logic       legacy;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Rises since last enable change
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         rises <= 6'h00;
      else if ($changed(serial_port_enable))
         rises <= 6'h00;
      else if ($rose(sclk) && rises != 6'h3F)
         rises <= rises + 6'h01;
   end
   // First link activity fixes the mode
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seen   <= 1'b0;
         legacy <= 1'b0;
      end else if (!seen && (serial_port_enable || sclk)) begin
         seen   <= 1'b1;
         legacy <= serial_port_enable;
      end
   end
   frame_len_a :
      assert property ($changed(serial_port_enable) && rises != 6'h00
         |-> rises == 6'h20) else $error("frame not 32 clocks");
   ena_setup_a :
      assert property ($rose(sclk) && serial_port_enable
         |-> $past(serial_port_enable, 8)) else $error("enable setup");
   read_flag_a :
      assert property ($rose(sclk) && serial_port_enable && rises == 6'h00
         |-> sdi) else $error("legacy frame not a read");
   bit_hold_a :
      assert property ($rose(sclk) |=> $stable(sdi) [*8])
      else $error("data moved while clock high");
   sdi_fall_a :
      assert property ($changed(sdi) |-> !sclk)
      else $error("data changed with clock high");
   legacy_data_a :
      assert property (legacy && serial_port_enable
         && $changed(lock_or_serial_out_pin) |-> rises >= 6'h08)
      else $error("read data before edge 8");
   legacy_rel_a :
      assert property ((legacy && rises == 6'h20) [*8]
         |-> lock_or_serial_out_pin == $past(lock_indicator_i))
      else $error("lock not back after edge 32");
   legacy_idle_a :
      assert property ((legacy && !serial_port_enable) [*8]
         |-> lock_or_serial_out_pin == $past(lock_indicator_i))
      else $error("lock missing while idle");
   multi_data_a :
      assert property (seen && !legacy && !serial_port_enable
         && $changed(lock_or_serial_out_pin)
         |-> rises != 6'h00 && rises <= 6'h18) else $error("data edge");
   multi_lock_a :
      assert property ((seen && !legacy && serial_port_enable) [*8]
         |-> lock_or_serial_out_pin == $past(lock_indicator_i))
      else $error("lock not back after enable");
endmodule : pspr_monitor

//--- dv/testbench.sv
// Purpose: Drives both serial port ends through host registers
// Assumes: Register file behind device is a fixed address pattern
// Notes:   Device mode is fixed per reset, so the run resets twice
`timescale 1ns/100ps
module testbench
   import pspr_pkg::*;
;
   logic        ref_clk_i;
   logic        rst_n_i;
   logic        lock_ind;
   logic [2:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [5:0]  rd_addr;
   logic [23:0] rd_data;
   logic        wr_stb;
   logic [4:0]  wr_addr;
   logic [23:0] wr_data;
   logic [1:0]  mode;
   logic        soft_rst;
   logic [31:0] q;
   int          fail_count = 0;
   int          checked = 0;
   int          cycles = 0;
   int          strobes = 0;
   int          resets = 0;
   pspr_if      link_if ();
   assign rd_data = {rd_addr, ~rd_addr, 12'hA5C};
   pspr_host i_pspr_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .ce_i(1'b1), .link(link_if.host), .avs_address_i(avs_address),
      .avs_read_i(avs_read), .avs_write_i(avs_write),
      .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
      .avs_waitrequest_o(avs_waitrequest));
   pspr_device i_pspr_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .ce_i(1'b1), .link(link_if.device), .lock_indicator_i(lock_ind),
      .rd_data_i(rd_data), .rd_addr_o(rd_addr), .wr_stb_o(wr_stb),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .mode_o(mode),
      .soft_rst_o(soft_rst));
   pspr_monitor i_pspr_monitor (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .serial_port_enable(link_if.serial_port_enable),
      .sclk(link_if.sclk), .sdi(link_if.sdi),
      .lock_or_serial_out_pin(link_if.lock_or_serial_out_pin),
      .lock_indicator_i(lock_ind));
   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (wr_stb === 1'b1)
         strobes++;
      if (soft_rst === 1'b1)
         resets++;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic check(input string n, input logic [31:0] s,
                        input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic bus(input logic [2:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // Runs one command and leaves the received word in q
   task automatic cmd(input pspr_kind_t k, input logic [5:0] a,
                      input logic [23:0] d, input logic [2:0] c);
      bus(PSPR_OFS_ADDR, 1'b1, {26'h0, a});
      bus(PSPR_OFS_WDATA, 1'b1, {8'h00, d});
      bus(PSPR_OFS_CHIP, 1'b1, {29'h0, c});
      bus(PSPR_OFS_CTRL, 1'b1, {29'h0, 1'b1, k});
      do bus(PSPR_OFS_CTRL, 1'b0, 32'h0);
      while (q[PSPR_STAT_DONE] !== 1'b1 || q[PSPR_STAT_BUSY] !== 1'b0);
      bus(PSPR_OFS_RDATA, 1'b0, 32'h0);
   endtask : cmd
   task automatic reset_all;
      rst_n_i <= 1'b0;
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
   endtask : reset_all
   task automatic legacy_reads;
      logic [5:0] a;
      for (int i = 0; i < 2; i++) begin
         a = i ? 6'h21 : 6'h3E;
         cmd(PSPR_K_LREAD, a, 24'h0, 3'h0);
         check("legacy data", q,
               {8'h0, a, ~a, 12'hA5C});
      end
      check("mode", {30'h0, mode}, {30'h0, PSPR_M_LEGACY});
   endtask : legacy_reads
   task automatic lock_idle;
      for (int v = 1; v >= 0; v--) begin
         lock_ind <= v[0];
         repeat (4) @(posedge ref_clk_i);
         check("pin", {31'h0, link_if.lock_or_serial_out_pin}, v);
      end
   endtask : lock_idle
   task automatic multi_write;
      int n;
      n = strobes;
      cmd(PSPR_K_MWRITE, 6'h05, 24'hC3A51E, 3'h0);
      check("strobes", strobes, n + 1);
      check("wr addr", {27'h0, wr_addr}, 32'h5);
      check("wr data", {8'h0, wr_data}, 32'hC3A51E);
      check("mode", {30'h0, mode}, {30'h0, PSPR_M_MULTI});
      cmd(PSPR_K_MWRITE, 6'h09, 24'h00FFFF, 3'h7);
      check("foreign", strobes, n + 1);
   endtask : multi_write
   task automatic multi_read;
      int n;
      n = resets;
      cmd(PSPR_K_MREAD, 6'h13, 24'h0, 3'h0);
      check("read", q,
            {8'h0, 6'h13, 6'h2C, 12'hA5C});
      cmd(PSPR_K_MWRITE, 6'h04, 24'h123456, 3'h0);
      check("kept addr", {26'h0, rd_addr}, 32'h13);
      cmd(PSPR_K_MWRITE, 6'h00, 24'h000020, 3'h0);
      check("soft reset", resets, n + 1);
      check("addr cleared", {26'h0, rd_addr}, 32'h0);
      check("mode", {30'h0, mode}, {30'h0, PSPR_M_MULTI});
   endtask : multi_read
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   initial begin
      rst_n_i       = 1'b0;
      lock_ind      = 1'b0;
      avs_address   = 3'h0;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      reset_all();
      legacy_reads();
      lock_idle();
      // Second reset frees the mode choice
      reset_all();
      multi_write();
      multi_read();
      end_sim();
   end
endmodule : testbench
